// File: output_signal_select_mux.sv
// Functional notes
// - Open-collector pin A selection resets to code 0, running flag.
// - Open-collector pin B selection resets to code 4, frequency detection.
// - Relay pin selection resets to code 99, major fault alarm.
// - Three virtual outputs each have a selection, reset 9999, inactive.
// - Codes 0-99 positive polarity; 100-199 same function inverted.
// - Code 0/100 routes the running flag.
// - Code 1/101 routes the at-set-speed flag.
// - Code 3/103 routes stall prevention active.
// - Code 4/104 routes frequency detection (fwd/rev thresholds upstream).
// - Code 7/107 routes regenerative brake prealarm at 85% duty.
// - Code 8/108 routes thermal prealarm at 85%; trip at 100%.
// - Code 11/111 routes operation ready, also true while running.
// - Code 12/112 routes current detection after qualification time.
// - Code 13/113 routes zero current after qualification time.
// - Codes 14/15/16 route feedback low, feedback high, loop forward.
// - Code 20/120 routes the brake opening request.
// - Code 25/125 routes the cooling fan fault.
// - Code 26/126 routes heatsink prealarm near 85% of trip.
// - Code 46/146 routes power-loss deceleration, latched until released.
// - Code 47/147 routes closed loop active.
// - Code 64/164 routes retry in progress.
// - Active function: source codes conduct, sink codes do not.
// - One code may drive several pins, each independently.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "out_select_params.svh"

module output_signal_select_mux (
    input wire logic clk_i, // 100 MHz clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic [7:0] reg_addr_i, // Register byte address
    input wire logic [15:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [15:0] reg_rdata_o, // Read data, cycle after strobe
    input wire out_select_pkg::drive_cond_t cond_i, // Drive status conditions
    input wire logic powerloss_release_i, // Clears latched power-loss flag
    output logic oc_pin_a_o, // Open-collector pin A, high = conducting
    output logic oc_pin_b_o, // Open-collector pin B, high = conducting
    output logic relay_output_pin_o, // Relay contact, high = closed
    output logic virtual_out_zero_o, // Network virtual output 0
    output logic virtual_out_one_o, // Network virtual output 1
    output logic virtual_out_two_o // Network virtual output 2
);

    // Selection registers
    logic [15:0] sel_q [6];
    logic [15:0] rdata_q;
    logic powerloss_q;
    out_select_pkg::out_pins_t pins_q;
    out_select_pkg::out_pins_t pins_d;
    out_select_pkg::reg_req_t req;
    logic [`COND_W-1:0] cond_vec;
    logic [15:0] rdata_d;
    logic [7:0] sel_addr [6];
    logic [5:0] sel_hit;

    // Bundle the register port
    assign req.addr = reg_addr_i;
    assign req.wdata = reg_wdata_i;
    assign req.wr = reg_wr_i;
    assign req.rd = reg_rd_i;

    // Register address of each selection
    assign sel_addr[0] = `ADDR_SEL_OC_A;
    assign sel_addr[1] = `ADDR_SEL_OC_B;
    assign sel_addr[2] = `ADDR_SEL_RELAY;
    assign sel_addr[3] = `ADDR_SEL_VOUT0;
    assign sel_addr[4] = `ADDR_SEL_VOUT1;
    assign sel_addr[5] = `ADDR_SEL_VOUT2;

    // latched power-loss flag: a new event wins over release
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            powerloss_q <= 1'b0;
        end else if (cond_i.powerloss_decel_flag) begin
            powerloss_q <= 1'b1;
        end else if (powerloss_release_i) begin
            powerloss_q <= 1'b0;
        end
    end

    // Condition vector indexed by internal bit positions
    // routing of basic flags
    assign cond_vec[`CB_RUNNING] = cond_i.running_flag;
    assign cond_vec[`CB_AT_SPEED] = cond_i.at_set_speed_flag;
    assign cond_vec[`CB_STALL] = cond_i.stall_prevent_flag;
    assign cond_vec[`CB_FREQ_DET] = cond_i.freq_detect_flag;
    assign cond_vec[`CB_REGEN_PRE] = cond_i.regen_brake_prealarm;
    assign cond_vec[`CB_THERMAL_PRE] = cond_i.thermal_prealarm;
    assign cond_vec[`CB_READY] = cond_i.operation_ready_flag | cond_i.running_flag;
    assign cond_vec[`CB_CUR_DET] = cond_i.current_detect_flag;
    assign cond_vec[`CB_ZERO_CUR] = cond_i.zero_current_flag;
    assign cond_vec[`CB_FB_LOW] = cond_i.feedback_low_limit_flag;
    assign cond_vec[`CB_FB_HIGH] = cond_i.feedback_high_limit_flag;
    assign cond_vec[`CB_LOOP_FWD] = cond_i.loop_forward_dir_flag;
    assign cond_vec[`CB_BRAKE_OPEN] = cond_i.brake_open_request;
    assign cond_vec[`CB_FAN_FAULT] = cond_i.fan_fault_flag;
    assign cond_vec[`CB_HEATSINK] = cond_i.heatsink_heat_prealarm;
    assign cond_vec[`CB_POWERLOSS] = powerloss_q | cond_i.powerloss_decel_flag;
    assign cond_vec[`CB_LOOP_ACTIVE] = cond_i.loop_active_flag;
    assign cond_vec[`CB_RETRY] = cond_i.retry_active_flag;
    assign cond_vec[`CB_ALARM] = cond_i.major_fault_alarm;

    // Decode one selection code into pin level
    function automatic logic pin_level(input logic [15:0] code,
                                       input logic [`COND_W-1:0] cv);
        logic sink;
        logic [15:0] base;
        logic hit;
        logic val;
        sink = 1'b0;
        base = 16'h0000;
        hit = 1'b1;
        val = 1'b0;
        if (code <= `SOURCE_LAST) begin
            base = code;
        end else if (code <= `SINK_LAST) begin
            base = code - `SINK_OFFSET;
            sink = 1'b1;
        end else begin
            hit = 1'b0;
        end
        case (base[6:0])
            `FN_RUNNING: val = cv[`CB_RUNNING];
            `FN_AT_SPEED: val = cv[`CB_AT_SPEED];
            `FN_STALL: val = cv[`CB_STALL];
            `FN_FREQ_DET: val = cv[`CB_FREQ_DET];
            `FN_REGEN_PRE: val = cv[`CB_REGEN_PRE];
            `FN_THERMAL_PRE: val = cv[`CB_THERMAL_PRE];
            `FN_READY: val = cv[`CB_READY];
            `FN_CUR_DET: val = cv[`CB_CUR_DET];
            `FN_ZERO_CUR: val = cv[`CB_ZERO_CUR];
            `FN_FB_LOW: val = cv[`CB_FB_LOW];
            `FN_FB_HIGH: val = cv[`CB_FB_HIGH];
            `FN_LOOP_FWD: val = cv[`CB_LOOP_FWD];
            `FN_BRAKE_OPEN: val = cv[`CB_BRAKE_OPEN];
            `FN_FAN_FAULT: val = cv[`CB_FAN_FAULT];
            `FN_HEATSINK: val = cv[`CB_HEATSINK];
            `FN_POWERLOSS: val = cv[`CB_POWERLOSS];
            `FN_LOOP_ACTIVE: val = cv[`CB_LOOP_ACTIVE];
            `FN_RETRY: val = cv[`CB_RETRY];
            `FN_ALARM: val = cv[`CB_ALARM];
            default: hit = 1'b0;
        endcase
        // source conducts when active, sink conducts when idle
        pin_level = hit & (val ^ sink);
    endfunction

    // each pin decodes its own selection independently
    assign pins_d.oc_pin_a = pin_level(sel_q[0], cond_vec);
    assign pins_d.oc_pin_b = pin_level(sel_q[1], cond_vec);
    assign pins_d.relay_output_pin = pin_level(sel_q[2], cond_vec);
    assign pins_d.virtual_out_zero = pin_level(sel_q[3], cond_vec);
    assign pins_d.virtual_out_one = pin_level(sel_q[4], cond_vec);
    assign pins_d.virtual_out_two = pin_level(sel_q[5], cond_vec);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

    // Selection registers, one per output
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sel
            assign sel_hit[gi] = (req.addr == sel_addr[gi]);
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sel_q[gi] <= (gi == 0) ? `RST_SEL_OC_A :
                                 (gi == 1) ? `RST_SEL_OC_B :
                                 (gi == 2) ? `RST_SEL_RELAY : `RST_SEL_VOUT;
                end else if (req.wr && sel_hit[gi]) begin
                    sel_q[gi] <= req.wdata;
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            if (sel_hit[i]) begin
                rdata_d = sel_q[i];
            end
        end
        if (req.addr == `ADDR_PIN_STATE) begin
            rdata_d = {10'h000, pins_q};
        end
        if (req.addr == `ADDR_COND_STATE) begin
            rdata_d = cond_vec[15:0];
        end
    end

    // Read data holds one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= req.rd ? rdata_d : 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign oc_pin_a_o = pins_q.oc_pin_a;
    assign oc_pin_b_o = pins_q.oc_pin_b;
    assign relay_output_pin_o = pins_q.relay_output_pin;
    assign virtual_out_zero_o = pins_q.virtual_out_zero;
    assign virtual_out_one_o = pins_q.virtual_out_one;
    assign virtual_out_two_o = pins_q.virtual_out_two;

    // Source-logic alarm on the relay follows the alarm one cycle later
    chk_relay_alarm_source: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[2] == `RST_SEL_RELAY && $stable(sel_q[2]))
            |=> (relay_output_pin_o == $past(cond_i.major_fault_alarm)))
        else $error("Relay pin does not follow alarm");

    // Sink code inverts the running flag on pin A
    chk_sink_inverts_run: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[0] == `SINK_OFFSET) |=> (oc_pin_a_o == !$past(cond_i.running_flag)))
        else $error("Sink code does not invert");

    // Unsupported code keeps pin B low
    chk_unsupported_low: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[1] > `SINK_LAST) |=> !oc_pin_b_o)
        else $error("Unsupported code drives pin");

    // Virtual output 0 stays low while unassigned
    chk_vout_unassigned: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[3] == `RST_SEL_VOUT) [*2] |-> !virtual_out_zero_o)
        else $error("Unassigned virtual output active");

    // Latched power-loss flag holds until released
    sequence powerloss_seen_s;
        cond_i.powerloss_decel_flag ##1 !cond_i.powerloss_decel_flag;
    endsequence
    chk_powerloss_latch: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        powerloss_seen_s |-> (powerloss_q || $past(powerloss_release_i)))
        else $error("Power-loss flag lost before release");

    // Ready code is on whenever running
    chk_ready_when_running: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[1] == {9'h000, `FN_READY} && $stable(sel_q[1]) && cond_i.running_flag)
            |=> oc_pin_b_o)
        else $error("Ready not shown while running");

    // Same code on two pins gives the same level
    chk_shared_code: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[0] == sel_q[1]) |=> (oc_pin_a_o == oc_pin_b_o))
        else $error("Pins sharing a code differ");

    // Read answer appears in the next cycle only
    chk_read_idle_zero: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !reg_rd_i |=> (reg_rdata_o == 16'h0000))
        else $error("Read data outside answer cycle");

    // Pin A follows the running flag at its reset code
    chk_pin_a_default: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[0] == `RST_SEL_OC_A && $stable(sel_q[0]))
            |=> (oc_pin_a_o == $past(cond_i.running_flag)))
        else $error("Pin A does not follow running");

    // Pin B follows frequency detection at its reset code
    chk_pin_b_default: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[1] == `RST_SEL_OC_B && $stable(sel_q[1]))
            |=> (oc_pin_b_o == $past(cond_i.freq_detect_flag)))
        else $error("Pin B does not follow frequency detection");

    // Unsupported code keeps pin A low
    chk_pin_a_unsupported: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[0] > `SINK_LAST) |=> !oc_pin_a_o)
        else $error("Unsupported code drives pin A");

    // Stall code in source form on virtual output 0
    chk_stall_source: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[3] == {9'h000, `FN_STALL} && $stable(sel_q[3]))
            |=> (virtual_out_zero_o == $past(cond_i.stall_prevent_flag)))
        else $error("Stall flag not routed");

    // Ready code in source form also covers running
    chk_ready_source: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[3] == {9'h000, `FN_READY} && $stable(sel_q[3]))
            |=> (virtual_out_zero_o == ($past(cond_i.operation_ready_flag) || $past(cond_i.running_flag))))
        else $error("Ready flag not routed");

    // Sink form of the alarm code inverts the alarm
    chk_alarm_sink: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (sel_q[4] == `SINK_LAST && $stable(sel_q[4]))
            |=> (virtual_out_one_o == !$past(cond_i.major_fault_alarm)))
        else $error("Sink alarm code does not invert");

    // Release with no new event clears the latch
    sequence release_clean_s;
        !cond_i.powerloss_decel_flag && powerloss_release_i;
    endsequence
    chk_powerloss_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        release_clean_s |=> !powerloss_q)
        else $error("Power-loss latch not released");

    // A new event sets the latch even during release
    chk_powerloss_set_wins: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cond_i.powerloss_decel_flag |=> powerloss_q)
        else $error("Power-loss event not latched");

    // A write to the pin A selection lands in the next cycle
    chk_write_lands: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (reg_wr_i && reg_addr_i == `ADDR_SEL_OC_A)
            |=> (sel_q[0] == $past(reg_wdata_i)))
        else $error("Selection write lost");

    // A read of the relay selection answers in the next cycle
    chk_read_answer: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == `ADDR_SEL_RELAY)
            |=> (reg_rdata_o == $past(sel_q[2])))
        else $error("Relay selection read wrong");

endmodule

`default_nettype wire

// File: out_select_params.svh
`ifndef OUT_SELECT_PARAMS_SVH
`define OUT_SELECT_PARAMS_SVH

// Register addresses (byte offsets on the plain register port)
`define ADDR_SEL_OC_A 8'h00
`define ADDR_SEL_OC_B 8'h04
`define ADDR_SEL_RELAY 8'h08
`define ADDR_SEL_VOUT0 8'h0c
`define ADDR_SEL_VOUT1 8'h10
`define ADDR_SEL_VOUT2 8'h14
`define ADDR_PIN_STATE 8'h18
`define ADDR_COND_STATE 8'h1c

// Reset selection codes
`define RST_SEL_OC_A 16'h0000
`define RST_SEL_OC_B 16'h0004
`define RST_SEL_RELAY 16'h0063
`define RST_SEL_VOUT 16'h270f

// Polarity split and code ranges
`define SINK_OFFSET 16'h0064
`define SINK_LAST 16'h00c7
`define SOURCE_LAST 16'h0063

// Function codes (source logic values)
`define FN_RUNNING 7'h00
`define FN_AT_SPEED 7'h01
`define FN_STALL 7'h03
`define FN_FREQ_DET 7'h04
`define FN_REGEN_PRE 7'h07
`define FN_THERMAL_PRE 7'h08
`define FN_READY 7'h0b
`define FN_CUR_DET 7'h0c
`define FN_ZERO_CUR 7'h0d
`define FN_FB_LOW 7'h0e
`define FN_FB_HIGH 7'h0f
`define FN_LOOP_FWD 7'h10
`define FN_BRAKE_OPEN 7'h14
`define FN_FAN_FAULT 7'h19
`define FN_HEATSINK 7'h1a
`define FN_POWERLOSS 7'h2e
`define FN_LOOP_ACTIVE 7'h2f
`define FN_RETRY 7'h40
`define FN_ALARM 7'h63

// Condition vector bit positions
`define CB_RUNNING 0
`define CB_AT_SPEED 1
`define CB_STALL 2
`define CB_FREQ_DET 3
`define CB_REGEN_PRE 4
`define CB_THERMAL_PRE 5
`define CB_READY 6
`define CB_CUR_DET 7
`define CB_ZERO_CUR 8
`define CB_FB_LOW 9
`define CB_FB_HIGH 10
`define CB_LOOP_FWD 11
`define CB_BRAKE_OPEN 12
`define CB_FAN_FAULT 13
`define CB_HEATSINK 14
`define CB_POWERLOSS 15
`define CB_LOOP_ACTIVE 16
`define CB_RETRY 17
`define CB_ALARM 18
`define COND_W 19

`endif

// File: out_select_pkg.sv
package out_select_pkg;

    // Drive status condition inputs, one bit each
    typedef struct packed {
        logic major_fault_alarm;
        logic retry_active_flag;
        logic loop_active_flag;
        logic powerloss_decel_flag;
        logic heatsink_heat_prealarm;
        logic fan_fault_flag;
        logic brake_open_request;
        logic loop_forward_dir_flag;
        logic feedback_high_limit_flag;
        logic feedback_low_limit_flag;
        logic zero_current_flag;
        logic current_detect_flag;
        logic operation_ready_flag;
        logic thermal_prealarm;
        logic regen_brake_prealarm;
        logic freq_detect_flag;
        logic stall_prevent_flag;
        logic at_set_speed_flag;
        logic running_flag;
    } drive_cond_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Physical and virtual pin group
    typedef struct packed {
        logic oc_pin_a;
        logic oc_pin_b;
        logic relay_output_pin;
        logic virtual_out_zero;
        logic virtual_out_one;
        logic virtual_out_two;
    } out_pins_t;

endpackage

// File: out_pin_reader.sv
`timescale 1ns/100ps
`default_nettype none

module out_pin_reader (
    input wire logic clk_i, // Controller sampling clock
    input wire logic reset_n_i, // Async reset, active low
    input wire out_select_pkg::out_pins_t pins_i, // Pin levels from the drive
    output var out_select_pkg::out_pins_t seen_o // Levels as last sampled
);
    // The controller only ever sees a sampled copy, never a level mid-edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seen_o <= '0;
        end else begin
            seen_o <= pins_i;
        end
    end
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    out_select_pkg::drive_cond_t cond_i = '0;
    logic powerloss_release_i = 1'b0;
    out_select_pkg::out_pins_t pins;
    out_select_pkg::out_pins_t seen;
    int err_count = 0;
    int compares = 0;

    // Clock, 10 ns period
    always #5 clk_i = ~clk_i;

    output_signal_select_mux dut (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .cond_i(cond_i),
        .powerloss_release_i(powerloss_release_i),
        .oc_pin_a_o(pins.oc_pin_a),
        .oc_pin_b_o(pins.oc_pin_b),
        .relay_output_pin_o(pins.relay_output_pin),
        .virtual_out_zero_o(pins.virtual_out_zero),
        .virtual_out_one_o(pins.virtual_out_one),
        .virtual_out_two_o(pins.virtual_out_two)
    );

    out_pin_reader reader (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .pins_i(pins),
        .seen_o(seen)
    );

    // Closing report and verdict
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clk_i);
        reg_addr_i <= addr;
        reg_wdata_i <= data;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle read strobe; data stands only in the following cycle
    task automatic reg_read(input logic [7:0] addr, output logic [15:0] data);
        @(posedge clk_i);
        reg_addr_i <= addr;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        data = reg_rdata_o;
    endtask

    task automatic set_cond(input out_select_pkg::drive_cond_t v);
        @(posedge clk_i);
        cond_i <= v;
    endtask

    // Drive register, then controller sample, then margin
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic test_reset_values();
        logic [15:0] d;
        reg_read(8'h00, d);
        check_word(d, 16'h0000, "pin A select reset");
        reg_read(8'h04, d);
        check_word(d, 16'h0004, "pin B select reset");
        reg_read(8'h08, d);
        check_word(d, 16'h0063, "relay select reset");
        reg_read(8'h0c, d);
        check_word(d, 16'h270f, "virtual 0 select reset");
        reg_read(8'h10, d);
        check_word(d, 16'h270f, "virtual 1 select reset");
        reg_read(8'h14, d);
        check_word(d, 16'h270f, "virtual 2 select reset");
        reg_read(8'h20, d);
        check_word(d, 16'h0000, "unmapped read");
    endtask

    task automatic test_default_routing();
        set_cond(19'h4_0009);
        settle();
        check_bit(seen.oc_pin_a, 1'b1, "pin A running");
        check_bit(seen.oc_pin_b, 1'b1, "pin B freq detect");
        check_bit(seen.relay_output_pin, 1'b1, "relay alarm");
        set_cond('1);
        settle();
        check_bit(seen.virtual_out_zero, 1'b0, "virtual 0 unassigned");
        check_bit(seen.virtual_out_one, 1'b0, "virtual 1 unassigned");
        check_bit(seen.virtual_out_two, 1'b0, "virtual 2 unassigned");
        set_cond('0);
        settle();
        check_bit(seen.relay_output_pin, 1'b0, "relay alarm off");
    endtask

    // Each code routed to three outputs at once, source and sink forms
    // codes
    task automatic test_code_table();
        int codes[19] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 20, 25, 26, 46, 47, 64, 99};
        out_select_pkg::drive_cond_t c;
        @(posedge clk_i);
        powerloss_release_i <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            reg_write(8'h0c, 16'(codes[i]));
            reg_write(8'h10, 16'(codes[i] + 100));
            reg_write(8'h14, 16'(codes[i]));
            c = '0;
            c[i] = 1'b1;
            set_cond(c);
            settle();
            check_bit(seen.virtual_out_zero, 1'b1, "source code active");
            check_bit(seen.virtual_out_one, 1'b0, "sink code active");
            check_bit(seen.virtual_out_two, 1'b1, "shared code active");
            set_cond('0);
            settle();
            check_bit(seen.virtual_out_zero, 1'b0, "source code idle");
            check_bit(seen.virtual_out_one, 1'b1, "sink code idle");
        end
    endtask

    task automatic test_powerloss_latch();
        @(posedge clk_i);
        powerloss_release_i <= 1'b0;
        reg_write(8'h00, 16'h002e);
        reg_write(8'h04, 16'h0092);
        set_cond(19'h0_8000);
        set_cond('0);
        settle();
        check_bit(seen.oc_pin_a, 1'b1, "power-loss held source");
        check_bit(seen.oc_pin_b, 1'b0, "power-loss held sink");
        @(posedge clk_i);
        powerloss_release_i <= 1'b1;
        settle();
        check_bit(seen.oc_pin_a, 1'b0, "power-loss released source");
        check_bit(seen.oc_pin_b, 1'b1, "power-loss released sink");
    endtask

    task automatic test_unsupported();
        int codes[6] = '{2, 80, 98, 102, 200, 9999};
        set_cond('1);
        for (int i = 0; i < 6; i++) begin
            reg_write(8'h00, 16'(codes[i]));
            reg_write(8'h04, 16'(codes[i]));
            settle();
            check_bit(seen.oc_pin_a, 1'b0, "unsupported code inactive");
            check_bit(seen.oc_pin_b, 1'b0, "unsupported code pin B");
        end
        set_cond('0);
    endtask

    // Sink and shared codes on the physical pins, then the status reads
    task automatic test_shared_sink();
        logic [15:0] d;
        reg_write(8'h00, 16'h0064);
        reg_write(8'h04, 16'h0064);
        set_cond(19'h0_0001);
        settle();
        check_bit(seen.oc_pin_a, 1'b0, "sink running active");
        check_bit(seen.oc_pin_b, 1'b0, "shared sink running active");
        set_cond('0);
        settle();
        check_bit(seen.oc_pin_a, 1'b1, "sink running idle");
        check_bit(seen.oc_pin_b, 1'b1, "shared sink running idle");
        reg_write(8'h04, 16'h000b);
        set_cond(19'h0_0001);
        settle();
        check_bit(seen.oc_pin_b, 1'b1, "ready while running");
        reg_read(8'h1c, d);
        check_word(d, 16'h0041, "condition state");
        reg_read(8'h18, d);
        check_word(d, 16'h0012, "pin state");
        set_cond('0);
    endtask

    // Cuts a hang short
    initial begin
        #500000;
        err_count++;
        $display("CHECK FAILED at %0t: run did not complete", $time);
        test_done();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        test_reset_values();
        test_default_routing();
        test_code_table();
        test_powerloss_latch();
        test_unsupported();
        test_shared_sink();
        test_done();
    end
endmodule

`default_nettype wire
